// file: src/cts_seq.sv
// Trigger, delay, exposure and output-window sequencer with register port
`timescale 1ns/1ns
module cts_seq
    import cts_pkg::*;
#(
    parameter int NUM_GPIO = 2,
    parameter int TIME_W = 24,
    parameter int BURST_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register port
    input wire cts_bus_t i_bus,
    output logic [DATA_W-1:0] o_rdata,
    // Trigger pin
    input wire logic i_trig_pin,
    // Sensor and transfer status
    input wire logic i_readout_done,
    input wire logic i_xfer_active,
    input wire logic i_ae_update,
    input wire logic i_ae_settled,
    // Output pins and events
    output logic [NUM_GPIO-1:0] o_gpio,
    output cts_evt_t o_evt
);
    typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_LATENCY, ST_DELAY, ST_EXPOSE,
                              ST_READOUT} cts_state_t;

    localparam int MODE_W = $bits(cts_mode_t);
    localparam int SEL_W = $bits(cts_sel_t);
    localparam int EVT_W = $bits(cts_evt_t);
    localparam int GCFG_W = NUM_GPIO * GPIO_STRIDE;
    localparam int LW = $clog2(LATENCY_CYC + 1);
    localparam logic [LW-1:0] LAT_LAST = LW'(LATENCY_CYC - 1);

    function automatic logic bus_hit(input cts_bus_t b, input logic [ADDR_W-1:0] a,
                                     input logic is_wr);
        bus_hit = (is_wr ? b.wr : b.rd) && b.addr == a;
    endfunction

    // True on the last microsecond of a count; a zero limit acts as one
    function automatic logic us_last(input logic [TIME_W-1:0] cnt,
                                     input logic [TIME_W-1:0] lim);
        us_last = ({1'b0, cnt} + 1'b1) >= {1'b0, lim};
    endfunction

    function automatic logic win_pick(input cts_win_t w, input logic [SEL_W-1:0] s);
        case (s)
            SEL_VSYNC: win_pick = w.vsync;
            SEL_STROBE: win_pick = w.strobe;
            SEL_EXPOSE: win_pick = w.expose;
            SEL_FRAME: win_pick = w.frame;
            SEL_XFER: win_pick = w.xfer;
            SEL_WAIT: win_pick = w.wait_trig;
            default: win_pick = 1'b0;
        endcase
    endfunction

    logic src_ff;
    logic pol_ff;
    cts_mode_t mode_ff;
    logic en_ff;
    logic [TIME_W-1:0] exp_us_ff;
    logic [TIME_W-1:0] delay_us_ff;
    logic [TIME_W-1:0] stb_delay_ff;
    logic [TIME_W-1:0] stb_width_ff;
    logic [BURST_W-1:0] burst_ff;
    logic [GCFG_W-1:0] gpio_cfg_ff;
    cts_evt_t evt_sticky_ff;

    cts_state_t state_ff;
    cts_state_t nxt_state;
    logic [LW-1:0] lat_cnt_ff;
    logic [TIME_W-1:0] us_cnt_ff;
    logic [BURST_W-1:0] frames_left_ff;
    logic [TIME_W:0] stb_cnt_ff;
    logic stb_run_ff;
    logic trig_prev_ff;
    cts_win_t win_ff;

    logic deb_level;
    logic trig_act;
    logic hw_edge;
    logic sw_trig;
    logic trig_evt;
    logic accept;
    logic reject;
    logic pulse_mode;
    logic burst_more;
    logic us_tick;
    logic stb_tick;
    logic expose_start;
    logic [TIME_W:0] stb_end;
    logic strobe_on;
    logic [DATA_W-1:0] rd_mux;

    // Configuration registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            src_ff <= CTRL_RST[CTRL_SRC_BIT];
            pol_ff <= CTRL_RST[CTRL_POL_BIT];
            mode_ff <= cts_mode_t'(CTRL_RST[CTRL_MODE_LSB +: MODE_W]);
            en_ff <= CTRL_RST[CTRL_EN_BIT];
            exp_us_ff <= EXPOSURE_RST[TIME_W-1:0];
            delay_us_ff <= DELAY_RST[TIME_W-1:0];
            stb_delay_ff <= STB_DELAY_RST[TIME_W-1:0];
            stb_width_ff <= STB_WIDTH_RST[TIME_W-1:0];
            burst_ff <= BURST_RST[BURST_W-1:0];
            gpio_cfg_ff <= GPIO_RST[GCFG_W-1:0];
        end else begin
            if (bus_hit(i_bus, ADDR_CTRL, 1'b1)) begin
                src_ff <= i_bus.wdata[CTRL_SRC_BIT];
                pol_ff <= i_bus.wdata[CTRL_POL_BIT];
                mode_ff <= cts_mode_t'(i_bus.wdata[CTRL_MODE_LSB +: MODE_W]);
                en_ff <= i_bus.wdata[CTRL_EN_BIT];
            end
            if (bus_hit(i_bus, ADDR_EXPOSURE, 1'b1)) begin
                exp_us_ff <= i_bus.wdata[TIME_W-1:0];
            end
            if (bus_hit(i_bus, ADDR_DELAY, 1'b1)) begin
                delay_us_ff <= i_bus.wdata[TIME_W-1:0];
            end
            if (bus_hit(i_bus, ADDR_STB_DELAY, 1'b1)) begin
                stb_delay_ff <= i_bus.wdata[TIME_W-1:0];
            end
            if (bus_hit(i_bus, ADDR_STB_WIDTH, 1'b1)) begin
                stb_width_ff <= i_bus.wdata[TIME_W-1:0];
            end
            if (bus_hit(i_bus, ADDR_BURST, 1'b1)) begin
                burst_ff <= i_bus.wdata[BURST_W-1:0];
            end
            if (bus_hit(i_bus, ADDR_GPIO, 1'b1)) begin
                gpio_cfg_ff <= i_bus.wdata[GCFG_W-1:0];
            end
        end
    end

    // Trigger qualification
    cts_debounce #(.STABLE(DEBOUNCE_CYC)) u_deb (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_trig_pin),
        .o_level(deb_level)
    );

    assign trig_act = pol_ff ? deb_level : ~deb_level;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_act;
        end
    end

    assign hw_edge = !src_ff && trig_act && !trig_prev_ff;
    assign sw_trig = src_ff && bus_hit(i_bus, ADDR_SWTRIG, 1'b1) &&
                     i_bus.wdata[SWTRIG_BIT];
    assign trig_evt = hw_edge || sw_trig;
    // Wait with enable already cleared is leaving, so a trigger there is refused
    assign accept = trig_evt && state_ff == ST_WAIT && en_ff;
    assign reject = trig_evt && !accept;
    // A software trigger has no width, so it falls back to timed exposure
    assign pulse_mode = mode_ff == MODE_PULSE && !src_ff;
    assign burst_more = mode_ff == MODE_BURST && frames_left_ff > 1'b1;

    cts_us_tick #(.DIV(US_CYC)) u_tick (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_restart(nxt_state != state_ff),
        .o_tick(us_tick)
    );

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (en_ff) nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (!en_ff) nxt_state = ST_OFF;
                else if (accept) nxt_state = ST_LATENCY;
            end
            ST_LATENCY: begin
                if (lat_cnt_ff == LAT_LAST) begin
                    nxt_state = (delay_us_ff == '0) ? ST_EXPOSE : ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (us_tick && us_last(us_cnt_ff, delay_us_ff)) nxt_state = ST_EXPOSE;
            end
            ST_EXPOSE: begin
                if (pulse_mode) begin
                    if (!trig_act) nxt_state = ST_READOUT;
                end else if (us_tick && us_last(us_cnt_ff, exp_us_ff)) begin
                    nxt_state = ST_READOUT;
                end
            end
            ST_READOUT: begin
                if (i_readout_done) begin
                    if (burst_more) nxt_state = ST_LATENCY;
                    else if (en_ff) nxt_state = ST_WAIT;
                    else nxt_state = ST_OFF;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || state_ff != ST_LATENCY) begin
            lat_cnt_ff <= '0;
        end else begin
            lat_cnt_ff <= lat_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || nxt_state != state_ff) begin
            us_cnt_ff <= '0;
        end else if (us_tick) begin
            us_cnt_ff <= us_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            frames_left_ff <= '0;
        end else if (accept) begin
            frames_left_ff <= (mode_ff == MODE_BURST) ? burst_ff : BURST_W'(1);
        end else if (state_ff == ST_READOUT && i_readout_done && frames_left_ff != '0) begin
            frames_left_ff <= frames_left_ff - 1'b1;
        end
    end

    // Strobe timer, on its own divider so exposure end cannot disturb it
    assign expose_start = nxt_state == ST_EXPOSE && state_ff != ST_EXPOSE;
    assign stb_end = {1'b0, stb_delay_ff} + {1'b0, stb_width_ff};
    assign strobe_on = stb_run_ff && stb_cnt_ff >= {1'b0, stb_delay_ff} &&
                       stb_cnt_ff < stb_end;

    cts_us_tick #(.DIV(US_CYC)) u_stb_tick (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_restart(expose_start),
        .o_tick(stb_tick)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stb_run_ff <= 1'b0;
            stb_cnt_ff <= '0;
        end else if (expose_start) begin
            stb_run_ff <= 1'b1;
            stb_cnt_ff <= '0;
        end else if (stb_run_ff && stb_tick) begin
            stb_cnt_ff <= stb_cnt_ff + 1'b1;
            if (stb_cnt_ff + 1'b1 >= stb_end) stb_run_ff <= 1'b0;
        end
    end

    // State windows line up with the state register; strobe and xfer lag their sources a cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            win_ff <= '0;
        end else begin
            win_ff.vsync <= expose_start;
            win_ff.strobe <= strobe_on;
            win_ff.expose <= nxt_state == ST_EXPOSE;
            win_ff.frame <= nxt_state == ST_EXPOSE || nxt_state == ST_READOUT;
            win_ff.xfer <= i_xfer_active;
            win_ff.wait_trig <= nxt_state == ST_WAIT;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_gpio <= '1;
        end else begin
            for (int i = 0; i < NUM_GPIO; i++) begin
                o_gpio[i] <= win_pick(win_ff, gpio_cfg_ff[i*GPIO_STRIDE +: SEL_W]) ~^
                             gpio_cfg_ff[i*GPIO_STRIDE + GPIO_POL_OFS];
            end
        end
    end

    // Event pulses and their sticky copy; a new event beats a clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_evt <= '0;
        end else begin
            o_evt.accepted <= accept;
            o_evt.rejected <= reject;
            o_evt.wait_start <= nxt_state == ST_WAIT && state_ff != ST_WAIT;
            o_evt.ae_update <= i_ae_update;
            o_evt.ae_settled <= i_ae_settled;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            evt_sticky_ff <= '0;
        end else if (bus_hit(i_bus, ADDR_EVENTS, 1'b1)) begin
            evt_sticky_ff <= (evt_sticky_ff & ~i_bus.wdata[EVT_W-1:0]) | o_evt;
        end else begin
            evt_sticky_ff <= evt_sticky_ff | o_evt;
        end
    end

    // Register read
    always_comb begin
        rd_mux = '0;
        case (i_bus.addr)
            ADDR_CTRL: begin
                rd_mux[CTRL_SRC_BIT] = src_ff;
                rd_mux[CTRL_POL_BIT] = pol_ff;
                rd_mux[CTRL_MODE_LSB +: MODE_W] = mode_ff;
                rd_mux[CTRL_EN_BIT] = en_ff;
            end
            ADDR_EXPOSURE: rd_mux[TIME_W-1:0] = exp_us_ff;
            ADDR_DELAY: rd_mux[TIME_W-1:0] = delay_us_ff;
            ADDR_STB_DELAY: rd_mux[TIME_W-1:0] = stb_delay_ff;
            ADDR_STB_WIDTH: rd_mux[TIME_W-1:0] = stb_width_ff;
            ADDR_BURST: rd_mux[BURST_W-1:0] = burst_ff;
            ADDR_GPIO: rd_mux[GCFG_W-1:0] = gpio_cfg_ff;
            ADDR_STATUS: rd_mux = DATA_W'({frames_left_ff, state_ff, trig_act});
            ADDR_EVENTS: rd_mux[EVT_W-1:0] = evt_sticky_ff;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_bus.rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rd_mux;
        end
    end

    // Cycles spent in the current state, read only by the checks below
    int st_cyc_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || nxt_state != state_ff) st_cyc_ff <= 0;
        else st_cyc_ff <= st_cyc_ff + 1;
    end

    chk_src_after_reset: assert property (@(posedge i_clk)
        $rose(i_rst_b) |-> !src_ff)
        else $error("trigger source not the pin after reset");

    chk_pol_map: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        hw_edge |-> deb_level == pol_ff)
        else $error("hardware edge taken at the wrong polarity");

    chk_latency_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        accept |=> (state_ff == ST_LATENCY) [*5] ##1 state_ff != ST_LATENCY)
        else $error("latency after an accepted trigger has the wrong length");

    chk_sw_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (sw_trig && state_ff == ST_WAIT && en_ff) |=> state_ff == ST_LATENCY)
        else $error("software trigger in wait did not start a frame");

    chk_delay_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == ST_DELAY && nxt_state != ST_DELAY) |->
            st_cyc_ff + 1 == int'(delay_us_ff) * US_CYC)
        else $error("trigger delay length differs from the setting");

    chk_exp_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == ST_EXPOSE && nxt_state != ST_EXPOSE && !pulse_mode && exp_us_ff != '0)
            |-> st_cyc_ff + 1 == int'(exp_us_ff) * US_CYC)
        else $error("timed exposure length differs from the setting");

    chk_pulse_end: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == ST_EXPOSE && pulse_mode) |-> (trig_act || nxt_state == ST_READOUT))
        else $error("pulse exposure outlived the trigger");

    chk_burst_again: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == ST_READOUT && i_readout_done && burst_more) |=> state_ff == ST_LATENCY)
        else $error("burst did not continue with the next frame");

    chk_reject_drop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        reject |=> o_evt.rejected &&
            !(state_ff == ST_LATENCY && $past(state_ff) == ST_WAIT) &&
            ($stable(frames_left_ff) || $past(i_readout_done)))
        else $error("trigger outside wait was not dropped and flagged");

    chk_expose_win: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(win_ff.expose) |-> win_ff.vsync && win_ff.frame)
        else $error("exposure start without frame window or sync");
endmodule

// file: pkg/cts_pkg.sv
// Constants and types for the camera trigger and exposure sequencer
package cts_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int US_PER_S = 1_000_000;
    localparam int US_CYC = CLK_HZ / US_PER_S;
    // Sensor start latency, a least time, so rounded up
    localparam int LATENCY_NS = 100;
    localparam int LATENCY_CYC = (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_NS = 1000;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_EXPOSURE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DELAY = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STB_DELAY = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STB_WIDTH = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_BURST = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_GPIO = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_SWTRIG = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_EVENTS = 8'h24;

    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_EN_BIT = 4;
    localparam int GPIO_STRIDE = 4;
    localparam int GPIO_POL_OFS = 3;
    localparam int SWTRIG_BIT = 0;

    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0012;
    localparam logic [DATA_W-1:0] EXPOSURE_RST = 32'h0000_03E8;
    localparam logic [DATA_W-1:0] DELAY_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STB_DELAY_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] STB_WIDTH_RST = 32'h0000_0064;
    localparam logic [DATA_W-1:0] BURST_RST = 32'h0000_0004;
    localparam logic [DATA_W-1:0] GPIO_RST = 32'h0000_0052;

    typedef enum logic [1:0] {MODE_TIMED, MODE_PULSE, MODE_BURST, MODE_SPARE} cts_mode_t;
    typedef enum logic [2:0] {SEL_VSYNC, SEL_STROBE, SEL_EXPOSE, SEL_FRAME, SEL_XFER,
                              SEL_WAIT} cts_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cts_bus_t;

    typedef struct packed {
        logic ae_settled;
        logic ae_update;
        logic wait_start;
        logic rejected;
        logic accepted;
    } cts_evt_t;

    typedef struct packed {
        logic wait_trig;
        logic xfer;
        logic frame;
        logic expose;
        logic strobe;
        logic vsync;
    } cts_win_t;
endpackage

// file: src/cts_us_tick.sv
// Restartable divider giving a one-cycle pulse per microsecond
`timescale 1ns/1ns
module cts_us_tick
    import cts_pkg::*;
#(
    parameter int DIV = US_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control and tick
    input wire logic i_restart,
    output logic o_tick
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;

    // Restart aligns the first tick to a full period after a state change
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_restart || cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign o_tick = (cnt_ff == LAST);
endmodule

// file: src/cts_debounce.sv
// Two-flop synchroniser and stability filter for the trigger pin
`timescale 1ns/1ns
module cts_debounce
    import cts_pkg::*;
#(
    parameter int STABLE = DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Raw pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    localparam int CW = $clog2(STABLE + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

    logic sync1_ff;
    logic sync2_ff;
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= i_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // A new level is taken only after it held for STABLE cycles
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || sync2_ff == o_level) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_level <= 1'b0;
        end else if (sync2_ff != o_level && cnt_ff == LAST) begin
            o_level <= sync2_ff;
        end
    end

    chk_deb_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $changed(o_level) |-> $past(cnt_ff) == LAST && o_level == $past(sync2_ff))
        else $error("debounced level changed before the input was stable");
endmodule

// file: verif/cts_trig_src.sv
// Model of the external trigger source driving the trigger pin
`timescale 1ns/1ns
module cts_trig_src #(
    parameter int LEN = 100
) (
    // Clock and command
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_act,
    // Trigger pin
    output logic o_pin
);
    int n_ff = 0;
    // Fired only while the sequencer waits; pulse held long and clean
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            n_ff <= LEN;
        end else if (n_ff > 0) begin
            n_ff <= n_ff - 1;
        end
    end
    // Active level follows the chosen polarity, idle is its inverse
    assign o_pin = (n_ff > 0) ? i_act : ~i_act;
endmodule

// file: verif/tb_cts_seq.sv
// Self-checking bench for the trigger and exposure sequencer
`timescale 1ns/1ns
module tb_cts_seq;
    import cts_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} cts_row_t;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    cts_bus_t i_bus = '0;
    logic i_readout_done = 1'b0;
    logic i_ae_update = 1'b0;
    logic i_ae_settled = 1'b0;
    localparam int PULSE_CYC = 100;
    logic go = 1'b0;
    logic pin;
    logic [DATA_W-1:0] o_rdata;
    logic [1:0] o_gpio;
    cts_evt_t o_evt;
    int fail_count = 0;
    int compares = 0;
    int n;
    cts_row_t rows[12];
    always #10 i_clk = ~i_clk;
    cts_trig_src #(.LEN(PULSE_CYC)) src (.i_clk(i_clk), .i_go(go), .i_act(1'b1), .o_pin(pin));
    cts_seq uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_trig_pin(pin), .i_readout_done(i_readout_done), .i_xfer_active(1'b0),
        .i_ae_update(i_ae_update), .i_ae_settled(i_ae_settled), .o_gpio(o_gpio),
        .o_evt(o_evt));
    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input int got, input int exp);
        chk_val(got, exp);
    endtask
    task automatic bus(input cts_row_t r);
        @(posedge i_clk);
        i_bus <= '{addr: r.a, wdata: r.d, wr: r.wr, rd: ~r.wr};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        if (!r.wr) chk_val(o_rdata, r.d);
    endtask
    task automatic lose();
        fail_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, 32'h0, 32'h1);
        report_and_stop();
    endtask
    // Bounded wait for an event pulse; looks first in the current cycle, since
    // a pulse launched by the edge that ended a bus call stands only until the next
    task automatic wait_evt(input int b, input int lim);
        #1;
        for (n = 0; n <= lim; n++) begin
            if (o_evt[b] === 1'b1) return;
            @(posedge i_clk);
            #1;
        end
        lose();
    endtask
    task automatic wait_pin(input logic lvl, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge i_clk);
            #1;
            if (o_gpio[0] === lvl) return;
        end
        lose();
    endtask
    task automatic pulse_done();
        @(posedge i_clk);
        i_readout_done <= 1'b1;
        @(posedge i_clk);
        i_readout_done <= 1'b0;
    endtask
    // Pin 0 shows the exposure window active low; times one exposure, then signals its readout done
    task automatic one_frame(input int lead, input int len);
        wait_pin(1'b0, 4000);
        chk_cyc(n, lead);
        chk_val(o_gpio[1], 1'b1);
        wait_pin(1'b1, 4000);
        chk_cyc(n, len);
        pulse_done();
    endtask
    initial begin
        rows = '{'{0, ADDR_CTRL, 32'h12}, '{0, ADDR_EXPOSURE, 32'h3E8},
            '{0, ADDR_DELAY, 32'h0}, '{0, ADDR_STB_DELAY, 32'h0},
            '{0, ADDR_STB_WIDTH, 32'h64}, '{0, ADDR_BURST, 32'h4},
            '{0, ADDR_GPIO, 32'h52}, '{0, 8'h30, 32'h0}, '{1, 8'h30, 32'hFF},
            '{0, 8'h30, 32'h0}, '{1, ADDR_EXPOSURE, 32'h1}, '{0, ADDR_EXPOSURE, 32'h1}};
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        chk_val(o_gpio, 2'h3);
        foreach (rows[i]) bus(rows[i]);
        chk_val(o_gpio, 2'h1);
        // Software source but disabled: the trigger finds no wait and is refused
        bus('{1, ADDR_CTRL, 32'h3});
        bus('{1, ADDR_SWTRIG, 32'h1});
        wait_evt(1, 3);
        bus('{1, ADDR_CTRL, 32'h12});
        // Hardware trigger, timed mode, no delay
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        wait_evt(0, 100);
        one_frame(LATENCY_CYC + 1, US_CYC);
        wait_evt(2, 10);
        // Pulse mode; the earlier pulse must first fall through the filter
        bus('{1, ADDR_CTRL, 32'h16});
        repeat (64) @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        wait_evt(0, 100);
        one_frame(LATENCY_CYC + 1, PULSE_CYC - LATENCY_CYC);
        wait_evt(2, 10);
        // Software trigger with a one microsecond delay
        bus('{1, ADDR_CTRL, 32'h13});
        bus('{1, ADDR_DELAY, 32'h1});
        bus('{1, ADDR_SWTRIG, 32'h1});
        wait_evt(0, 3);
        one_frame(LATENCY_CYC + 1 + US_CYC, US_CYC);
        wait_evt(2, 10);
        // Burst of two frames from a single trigger
        bus('{1, ADDR_CTRL, 32'h1B});
        bus('{1, ADDR_BURST, 32'h2});
        bus('{1, ADDR_SWTRIG, 32'h1});
        wait_evt(0, 3);
        one_frame(LATENCY_CYC + 1 + US_CYC, US_CYC);
        one_frame(LATENCY_CYC + 1 + US_CYC, US_CYC);
        wait_evt(2, 10);
        @(posedge i_clk);
        i_ae_update <= 1'b1;
        i_ae_settled <= 1'b1;
        @(posedge i_clk);
        i_ae_update <= 1'b0;
        i_ae_settled <= 1'b0;
        wait_evt(3, 3);
        wait_evt(4, 3);
        // Reset in mid-run must bring the source back to the pin
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        bus('{0, ADDR_CTRL, 32'h12});
        report_and_stop();
    end
endmodule
